// File: verilog/rpg_pkg.sv
// Package of constants and types for the repeating pattern generator
// Function
// RULE_01: Each output word drives 32 lines
// RULE_02: Buffer words each last one time slice
// RULE_03: Buffer holds 16384 words; host fits repeat
// RULE_04: Host builds pixels of 10 or 20 slices
// RULE_05: Host keeps pixel at least 10 slices
// RULE_06: Host places convert and latch sequence per pixel
// RULE_07: Halt and clear buffer before reload
// RULE_08: Direct code routes written words straight out
// RULE_09: Repeat code feeds lines from buffer
// RULE_10: Joined code couples both 16-bit halves
// RULE_11: Host writes pass count in both halves
// RULE_12: Launch code replays buffer programmed passes
// RULE_13: Retransmit interrupt after each non-final pass
// RULE_14: Zero enable clears pending; selects source
// RULE_15: Interrupt only when master arm written
// RULE_16: Drain-complete interrupt after final pass
// RULE_17: Host halts then returns to direct path
// RULE_18: Host sends start, repeat, end sections
// RULE_19: Lines hold last word when idle
package rpg_pkg;
  // ************************************************************
  // Sizes and timing
  // ************************************************************
  localparam int WORD_W = 32;
  localparam int DEPTH = 16384;
  localparam int ADDR_W = 14;
  localparam int CLOCK_MHZ = 50;
  localparam int SLICE_NS = 200;
  // Shortest time: round up, at least one cycle
  localparam int SLICE_CYC_I = (SLICE_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [7:0] SLICE_CYC = 8'(SLICE_CYC_I < 1 ? 1 : SLICE_CYC_I);
  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_DIRECT = 8'h00;
  localparam logic [7:0] OFS_BUFFER = 8'h04;
  localparam logic [7:0] OFS_PATH = 8'h08;
  localparam logic [7:0] OFS_COUPLE = 8'h0c;
  localparam logic [7:0] OFS_PASSES = 8'h10;
  localparam logic [7:0] OFS_RUN = 8'h14;
  localparam logic [7:0] OFS_SRC_EN = 8'h18;
  localparam logic [7:0] OFS_ARM = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_CLEAR = 8'h24;
  localparam logic [7:0] OFS_LEVEL = 8'h28;
  // ************************************************************
  // Codes
  // ************************************************************
  localparam logic [1:0] DIRECT_PATH_CODE = 2'h1;
  localparam logic [1:0] REPEAT_PATH_CODE = 2'h2;
  localparam logic [1:0] HALVES_JOINED_CODE = 2'h1;
  localparam logic [1:0] LAUNCH_CODE = 2'h1;
  localparam logic [1:0] HALT_CODE = 2'h2;
  localparam logic [1:0] BUFFER_CLEAR_CODE = 2'h3;
  localparam logic [1:0] PASS_RESTART_SOURCE = 2'h1;
  localparam logic [1:0] DRAIN_COMPLETE_SOURCE = 2'h2;
  localparam logic [7:0] MASTER_ARM_VALUE = 8'ha5;
  localparam int SRC_RESTART_BIT = 0;
  localparam int SRC_DRAIN_BIT = 1;
  // ************************************************************
  // Reset values and state encoding
  // ************************************************************
  localparam logic [WORD_W-1:0] LINES_RST = 32'h0000_0000;
  localparam logic [15:0] PASSES_RST = 16'h0001;
  typedef enum logic [1:0] {RPG_IDLE = 2'b00, RPG_RUN = 2'b01, RPG_WRAP = 2'b11} rpg_state_t;
endpackage : rpg_pkg

// File: verilog/rpg_buffer.sv
// Pattern buffer memory with write pointer and read port
`timescale 1ns/10ps
module rpg_buffer (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Fill side
  input wire logic wr_en,
  input wire logic [rpg_pkg::WORD_W-1:0] wr_data,
  input wire logic clear,
  output logic [rpg_pkg::ADDR_W:0] count,
  // Replay side
  input wire logic [rpg_pkg::ADDR_W-1:0] rd_addr,
  output logic [rpg_pkg::WORD_W-1:0] rd_data
);
  import rpg_pkg::*;
  logic [WORD_W-1:0] mem [DEPTH];
  logic full;
  assign full = (count == (ADDR_W+1)'(DEPTH)); // RULE_03
  // Stored words; writes past the end are dropped
  always_ff @(posedge clock) begin
    if (wr_en && !full) begin
      mem[count[ADDR_W-1:0]] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
  // Fill level; clear discards everything at once
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (clear) begin
      count <= '0; // RULE_07
    end else if (wr_en && !full) begin
      count <= count + 1'b1;
    end
  end
endmodule : rpg_buffer

// File: verilog/rpg_slice_timer.sv
// Time slice tick generator
`timescale 1ns/10ps
module rpg_slice_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Control
  input wire logic run,
  output logic tick
);
  import rpg_pkg::*;
  logic [7:0] cnt;
  // One pulse per slice while running
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end else if (!run) begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= (cnt == SLICE_CYC - 8'h01); // RULE_02
      cnt <= (cnt == SLICE_CYC - 8'h01) ? 8'h00 : cnt + 8'h01;
    end
  end
endmodule : rpg_slice_timer

// File: verilog/rpg_top.sv
// Repeating pattern generator: Wishbone slave, direct and replay paths
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/10ps
module rpg_top (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pattern lines
  output logic [rpg_pkg::WORD_W-1:0] lines,
  // Processor interrupt
  output logic irq,
  output logic event_toggle
);
  import rpg_pkg::*;

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic req;
  logic wr;
  logic full_word;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign full_word = (wb_sel_i == 4'hf);
  assign wr = req && wb_we_i;
  logic wr_direct, wr_buffer, wr_path, wr_couple, wr_passes, wr_run, wr_src, wr_arm, wr_clear;
  assign wr_direct = wr && full_word && (wb_adr_i == OFS_DIRECT);
  assign wr_buffer = wr && full_word && (wb_adr_i == OFS_BUFFER);
  assign wr_path = wr && wb_sel_i[0] && (wb_adr_i == OFS_PATH);
  assign wr_couple = wr && wb_sel_i[0] && (wb_adr_i == OFS_COUPLE);
  assign wr_passes = wr && (wb_adr_i == OFS_PASSES);
  assign wr_run = wr && wb_sel_i[0] && (wb_adr_i == OFS_RUN);
  assign wr_src = wr && wb_sel_i[0] && (wb_adr_i == OFS_SRC_EN);
  assign wr_arm = wr && wb_sel_i[0] && (wb_adr_i == OFS_ARM);
  assign wr_clear = wr && wb_sel_i[0] && (wb_adr_i == OFS_CLEAR);

  // ************************************************************
  // Control registers
  // ************************************************************
  logic repeat_sel;
  logic joined;
  logic [15:0] passes_lo;
  logic [15:0] passes_hi;
  logic [1:0] src_en;
  logic armed;
  logic [1:0] status;
  rpg_state_t state;
  rpg_state_t next_state;
  logic [15:0] pass_left;
  logic [ADDR_W-1:0] rd_addr;
  logic [ADDR_W:0] count;
  logic [ADDR_W:0] emitted;
  logic [WORD_W-1:0] rd_data;
  logic tick;
  logic running;
  logic launch;
  logic halt;
  logic buf_clear;
  logic buf_write;
  logic repeat_sel_code;
  assign repeat_sel_code = (wb_dat_i[1:0] == REPEAT_PATH_CODE);
  assign launch = wr_run && (wb_dat_i[1:0] == LAUNCH_CODE) && (count != '0);
  assign halt = wr_run && (wb_dat_i[1:0] == HALT_CODE);
  assign buf_clear = (wr_run && (wb_dat_i[1:0] == BUFFER_CLEAR_CODE)) || (wr_path && repeat_sel_code); // RULE_07
  assign buf_write = wr_buffer && (state == RPG_IDLE);

  // Output path selector
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      repeat_sel <= 1'b0;
    end else if (wr_path && wb_dat_i[1:0] == DIRECT_PATH_CODE) begin
      repeat_sel <= 1'b0; // RULE_08
    end else if (wr_path && repeat_sel_code) begin
      repeat_sel <= 1'b1; // RULE_09
    end
  end

  // Half coupling; decoupled halves replay only the low half count
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      joined <= 1'b0;
    end else if (wr_couple) begin
      joined <= (wb_dat_i[1:0] == HALVES_JOINED_CODE); // RULE_10
    end
  end

  // Pass count halves, byte lanes honoured
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      passes_lo <= PASSES_RST;
      passes_hi <= PASSES_RST;
    end else if (wr_passes) begin
      if (wb_sel_i[0]) passes_lo[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) passes_lo[15:8] <= wb_dat_i[15:8];
      if (wb_sel_i[2]) passes_hi[7:0] <= wb_dat_i[23:16];
      if (wb_sel_i[3]) passes_hi[15:8] <= wb_dat_i[31:24];
    end
  end

  // ************************************************************
  // Replay engine
  // ************************************************************
  logic last_word;
  logic [15:0] start_passes;
  // Joined halves must agree; a mismatch takes the smaller count
  assign start_passes = joined ? ((passes_lo < passes_hi) ? passes_lo : passes_hi) : passes_lo;
  assign last_word = (rd_addr == 14'(count - 1'b1));
  assign running = (state != RPG_IDLE);

  // State: idle, run through buffer, wrap at pass end
  always_comb begin
    next_state = state;
    unique case (state)
      RPG_IDLE: if (launch && start_passes != 16'h0000) next_state = RPG_RUN; // RULE_12
      RPG_RUN: if (halt) next_state = RPG_IDLE;
        else if (tick && last_word) next_state = (pass_left == 16'h0001) ? RPG_IDLE : RPG_WRAP;
      RPG_WRAP: next_state = halt ? RPG_IDLE : RPG_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= RPG_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Read address and remaining passes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_addr <= '0;
      pass_left <= 16'h0000;
    end else if (state == RPG_IDLE) begin
      rd_addr <= '0;
      pass_left <= start_passes;
    end else if (state == RPG_RUN && tick) begin
      rd_addr <= last_word ? '0 : rd_addr + 1'b1;
      if (last_word) pass_left <= pass_left - 16'h0001; // RULE_12
    end
  end

  // Words emitted count, only to show progress
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      emitted <= '0;
    end else if (state == RPG_IDLE) begin
      emitted <= '0;
    end else if (state == RPG_RUN && tick) begin
      emitted <= last_word ? '0 : emitted + 1'b1;
    end
  end

  // ************************************************************
  // Output lines
  // ************************************************************
  // Buffer read data lags the address by one cycle, so words are
  // sampled one cycle after each tick, keeping each for one slice.
  logic tick_d;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick_d <= 1'b0;
      lines <= LINES_RST;
    end else begin
      tick_d <= tick && state == RPG_RUN;
      if (!repeat_sel && wr_direct) begin
        lines <= wb_dat_i; // RULE_08 RULE_01
      end else if (repeat_sel && tick_d) begin
        lines <= rd_data; // RULE_09 RULE_02
      end
    end
  end
  // Otherwise lines keep the last emitted word (RULE_19 holds by no assignment)

  // ************************************************************
  // Interrupts
  // ************************************************************
  logic ev_restart;
  logic ev_drain;
  logic [1:0] ev;
  logic [1:0] clr;
  assign ev_restart = state == RPG_RUN && tick && last_word && pass_left != 16'h0001; // RULE_13
  assign ev_drain = state == RPG_RUN && tick && last_word && pass_left == 16'h0001; // RULE_16
  assign ev = {ev_drain, ev_restart};
  assign clr = (wr_clear ? wb_dat_i[1:0] : 2'b00) | ((wr_src && wb_dat_i[1:0] == 2'b00) ? 2'b11 : 2'b00);

  // Source enable; zero clears pending
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      src_en <= 2'b00;
      armed <= 1'b0;
    end else begin
      if (wr_src) src_en <= wb_dat_i[1:0]; // RULE_14
      if (wr_src && wb_dat_i[1:0] == 2'b00) armed <= 1'b0;
      else if (wr_arm) armed <= (wb_dat_i[7:0] == MASTER_ARM_VALUE); // RULE_15
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      status <= 2'b00;
    end else begin
      status <= (status & ~clr) | ev; // RULE_14
    end
  end

  // Interrupt level and event toggle
  logic [1:0] fire;
  assign fire = ev & src_en;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
      event_toggle <= 1'b0;
    end else begin
      irq <= armed && |(((status & ~clr) | ev) & src_en); // RULE_15
      if (armed && |fire) event_toggle <= ~event_toggle; // RULE_15 RULE_16
    end
  end

  // ************************************************************
  // Read mux and ack
  // ************************************************************
  logic [31:0] rdata;
  assign rdata = (wb_adr_i == OFS_DIRECT) ? lines :
    (wb_adr_i == OFS_PATH) ? (repeat_sel ? 32'(REPEAT_PATH_CODE) : 32'(DIRECT_PATH_CODE)) :
    (wb_adr_i == OFS_COUPLE) ? {31'h0, joined} :
    (wb_adr_i == OFS_PASSES) ? {passes_hi, passes_lo} :
    (wb_adr_i == OFS_RUN) ? {15'h0, emitted, 1'b0, running} :
    (wb_adr_i == OFS_SRC_EN) ? {30'h0, src_en} :
    (wb_adr_i == OFS_ARM) ? {31'h0, armed} :
    (wb_adr_i == OFS_STATUS) ? {30'h0, status} :
    (wb_adr_i == OFS_LEVEL) ? {pass_left, 1'b0, count} : 32'h0000_0000;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req && !wb_we_i) ? rdata : 32'h0000_0000;
    end
  end

  // ************************************************************
  // Submodules
  // ************************************************************
  rpg_buffer u_buffer (
    .clock(clock),
    .arst_n(arst_n),
    .wr_en(buf_write),
    .wr_data(wb_dat_i),
    .clear(buf_clear),
    .count(count),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  rpg_slice_timer u_timer (
    .clock(clock),
    .arst_n(arst_n),
    .run(running),
    .tick(tick)
  );
endmodule : rpg_top

// File: verif/rpg_top_asserts.sv
// Concurrent checks on the pattern generator ports
`timescale 1ns/10ps
module rpg_top_asserts
  import rpg_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pattern lines and interrupt
  input wire logic [rpg_pkg::WORD_W-1:0] lines,
  input wire logic irq,
  input wire logic event_toggle
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ************************************************************
  // Request decode and shadow state
  // ************************************************************
  wire taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_taken = taken && wb_we_i;
  wire direct_wr = wr_taken && wb_adr_i == OFS_DIRECT && wb_sel_i == 4'hf;
  logic [1:0] path_q;
  logic armed_q;
  // Path starts unknown, so the direct check waits for an explicit path write
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      path_q <= 2'h0;
      armed_q <= 1'b0;
    end else if (wr_taken) begin
      if (wb_adr_i == OFS_PATH) path_q <= wb_dat_i[1:0];
      if (wb_adr_i == OFS_ARM) armed_q <= wb_dat_i[7:0] == MASTER_ARM_VALUE;
      if (wb_adr_i == OFS_SRC_EN && wb_dat_i[1:0] == 2'h0) armed_q <= 1'b0;
    end
  end
  sequence s_taken;
    taken;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_one_pulse: assert property (s_taken |=> s_ack_pulse)
    else $error("ack is not one pulse after the request");
  a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(taken))
    else $error("ack without a request");
  a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_direct_to_lines: assert property (direct_wr && path_q == DIRECT_PATH_CODE |=> lines == $past(wb_dat_i))
    else $error("direct word did not reach the lines");
  a_direct_read_back: assert property (taken && !wb_we_i && wb_adr_i == OFS_DIRECT |=> wb_dat_o == $past(lines))
    else $error("direct read differs from lines");
  // Replayed words hold for at least nine cycles; only a direct write may change lines sooner
  a_word_holds_slice: assert property ($changed(lines) && !$past(direct_wr) |=> $stable(lines) [*8])
    else $error("replayed word shorter than a slice");
  a_disarm_drops_irq: assert property (wr_taken && wb_adr_i == OFS_SRC_EN && wb_dat_i[1:0] == 2'h0 |=> ##1 !irq)
    else $error("irq still high after zero enable");
  a_toggle_needs_arm: assert property ($changed(event_toggle) |-> armed_q || $past(armed_q))
    else $error("event toggled while disarmed");
  a_irq_needs_arm: assert property (irq |-> armed_q || $past(armed_q))
    else $error("irq high while disarmed");
endmodule : rpg_top_asserts
bind rpg_top rpg_top_asserts u_rpg_top_asserts (.clock(clock), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lines(lines), .irq(irq), .event_toggle(event_toggle));

// File: verif/rpg_line_sink.sv
// Far-side model: samples the pattern lines as the detector and converter inputs do
`timescale 1ns/10ps
module rpg_line_sink (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Pattern lines
  input wire logic [rpg_pkg::WORD_W-1:0] lines
);
  import rpg_pkg::*;
  logic [WORD_W-1:0] word_q[$];
  int stamp_q[$];
  int cycle;
  logic [WORD_W-1:0] last;
  // All lines are latched together; a new state is logged with its cycle for slice timing
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cycle = 0;
      last = '0;
    end else begin
      cycle = cycle + 1;
      if (lines !== last) begin
        word_q.push_back(lines);
        stamp_q.push_back(cycle);
        last = lines;
      end
    end
  end
endmodule : rpg_line_sink

// File: verif/test_rpg_top.sv
// Self-checking bench for the repeating pattern generator
`timescale 1ns/10ps
module test_rpg_top;
  import rpg_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [WORD_W-1:0] lines;
  logic irq;
  logic event_toggle;
  logic tog_prev = 1'b0;
  logic [31:0] rd;
  logic [31:0] pat [3] = '{32'h1111_0001, 32'h2222_0002, 32'h4444_0004};
  int errors = 0;
  int tests_run = 0;
  int toggles = 0;
  int cycles = 0;
  int base;
  always #10 clock = ~clock;
  rpg_top u_rpg_top (.clock(clock), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .lines(lines), .irq(irq), .event_toggle(event_toggle));
  rpg_line_sink u_rpg_line_sink (.clock(clock), .arst_n(arst_n), .lines(lines));
  // Count event flips; the ceiling is far above the few hundred cycles the tests need
  always @(posedge clock) begin
    tog_prev <= event_toggle;
    if (arst_n && event_toggle !== tog_prev) toggles++;
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("ERROR %0t timeout", $time);
      summarize();
    end
  end
  // ************************************************************
  // Bus and compare tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, want);
    end
  endtask : chk
  // Classic cycle: hold until ack is sampled, then release for at least one cycle
  task automatic wb_access(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_access
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_access(1'b1, adr, dat, 4'hf);
  endtask : wr
  task automatic rdv(input logic [7:0] adr);
    wb_access(1'b0, adr, 32'h0, 4'hf);
  endtask : rdv
  task automatic rdchk(input logic [7:0] adr, input logic [31:0] want);
    rdv(adr);
    chk(rd, want);
  endtask : rdchk
  task automatic summarize();
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    chk(lines, 32'h0);
    chk({30'h0, irq, event_toggle}, 32'h0);
    rdchk(OFS_PASSES, 32'h0001_0001);
    wr(8'hfc, 32'hffff_ffff);
    rdchk(8'hfc, 32'h0);
    $display("test reset done");
    wr(OFS_PATH, {30'h0, DIRECT_PATH_CODE});
    wr(OFS_DIRECT, 32'hc3c3_5a5a);
    chk(lines, 32'hc3c3_5a5a);
    wb_access(1'b1, OFS_DIRECT, 32'h0, 4'h3);
    rdchk(OFS_DIRECT, 32'hc3c3_5a5a);
    $display("test direct done");
    wr(OFS_PATH, {30'h0, REPEAT_PATH_CODE});
    wr(OFS_DIRECT, 32'hdead_beef);
    chk(lines, 32'hc3c3_5a5a);
    // Host side: three-word repeat section; the one-lane buffer write after it is not stored
    for (int i = 0; i < 3; i++) wr(OFS_BUFFER, pat[i]);
    wb_access(1'b1, OFS_BUFFER, 32'h8888_0008, 4'h1);
    rdv(OFS_LEVEL);
    chk(rd & 32'h7fff, 32'h3);
    wr(OFS_COUPLE, {30'h0, HALVES_JOINED_CODE});
    wr(OFS_PASSES, 32'h0003_0002);
    wr(OFS_SRC_EN, 32'h0);
    wr(OFS_SRC_EN, {30'h0, PASS_RESTART_SOURCE});
    wr(OFS_ARM, {24'h0, MASTER_ARM_VALUE});
    base = u_rpg_line_sink.word_q.size();
    wr(OFS_RUN, {30'h0, LAUNCH_CODE});
    for (int n = 0; n < 100; n++) begin
      rdv(OFS_RUN);
      if (rd[0] === 1'b0) break;
    end
    // Joined halves 3 and 2 give two passes of three words
    chk(u_rpg_line_sink.word_q.size() - base, 32'd6);
    for (int i = 0; i < 6; i++) begin
      chk(u_rpg_line_sink.word_q[base + i], pat[i % 3]);
      if (i > 0) chk(u_rpg_line_sink.stamp_q[base + i] - u_rpg_line_sink.stamp_q[base + i - 1], SLICE_CYC);
    end
    chk(toggles, 32'd1);
    rdchk(OFS_STATUS, 32'h3);
    chk(irq, 1'b1);
    chk(lines, pat[2]);
    wr(OFS_CLEAR, 32'h1);
    chk(irq, 1'b0);
    wr(OFS_SRC_EN, {30'h0, DRAIN_COMPLETE_SOURCE});
    // The new enable reaches the registered level one cycle after the ack
    @(posedge clock);
    chk(irq, 1'b1);
    wr(OFS_SRC_EN, 32'h0);
    chk(irq, 1'b0);
    rdchk(OFS_STATUS, 32'h0);
    $display("test replay done");
    wr(OFS_RUN, {30'h0, LAUNCH_CODE});
    wr(OFS_RUN, {30'h0, HALT_CODE});
    rdv(OFS_RUN);
    chk(rd[0], 1'b0);
    rdchk(OFS_STATUS, 32'h0);
    wr(OFS_RUN, {30'h0, BUFFER_CLEAR_CODE});
    rdv(OFS_LEVEL);
    chk(rd & 32'h7fff, 32'h0);
    wr(OFS_RUN, {30'h0, LAUNCH_CODE});
    rdv(OFS_RUN);
    chk(rd[0], 1'b0);
    $display("test halt done");
    wr(OFS_PATH, {30'h0, DIRECT_PATH_CODE});
    wr(OFS_DIRECT, 32'h0f0f_f0f0);
    chk(lines, 32'h0f0f_f0f0);
    $display("test return done");
    summarize();
  end
endmodule : test_rpg_top
